// ===== afc_pkg.sv
package afc_pkg;
    localparam logic [7:0] AFC_ADDR_BASE   = 8'h02;
    localparam logic [7:0] AFC_ADDR_ZLO    = 8'h06;
    localparam logic [7:0] AFC_ADDR_ZHI    = 8'h07;
    localparam logic [7:0] AFC_ADDR_STAT1  = 8'h08;
    localparam logic [7:0] AFC_ADDR_STAT2  = 8'h09;
    localparam logic [7:0] AFC_ADDR_FEAT2  = 8'h0E;
    localparam logic [7:0] AFC_WRAP_SHORT  = 8'h07;
    localparam logic [7:0] AFC_WRAP_LONG   = 8'h09;
    localparam logic [7:0] AFC_FEAT2_RESET = 8'h00;
    localparam int         AFC_BIT_WRAP    = 0;
    localparam int         AFC_BIT_BURST   = 1;
    localparam int         AFC_BIT_SPISTAT = 2;
    localparam int         AFC_BIT_FSTAT   = 3;
    localparam int         AFC_BIT_WRCLR   = 4;
    localparam int         AFC_BIT_STREAM  = 5;
    localparam int         AFC_BIT_POL     = 6;
    localparam int         AFC_BIT_EXTEN   = 7;
    localparam logic [2:0] AFC_MODE_ONE_SHOT = 3'b111;
    localparam int         AFC_FIFO_DEPTH  = 32;
    localparam int         AFC_SAMPLE_W    = 48;
    localparam logic [3:0] AFC_TOKEN_BITS  = 4'h8;
    typedef enum logic [1:0] {
        AFC_TOK_IDLE,
        AFC_TOK_SHIFT,
        AFC_TOK_DONE
    } afc_tok_type;
endpackage

// ===== afc_feature_config.sv
`timescale 1ns/1ps
module afc_fifo #(
    parameter int WIDTH = 48,
    parameter int DEPTH = 32
) (
    input  wire logic             clk,
    input  wire logic             reset_n,
    input  wire logic             in_valid,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             overwrite,
    input  wire logic             hold,
    input  wire logic             out_ready,
    output logic                  in_ready,
    output logic                  out_valid,
    output logic [WIDTH-1:0]      out_data,
    output logic [$clog2(DEPTH):0] count
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [AW:0]      cnt_q;
    logic [AW:0]      cnt_d;
    logic             push;
    logic             pop;
    logic             drop;
    logic             ready_q;

    assign pop  = out_ready && (cnt_q != '0);
    assign push = in_valid && ready_q && !hold
                  && ((cnt_q != FULL) || overwrite);
    assign drop = push && (cnt_q == FULL) && !pop;
    assign cnt_d = cnt_q + (AW+1)'(push && !drop) - (AW+1)'(pop);
    assign in_ready  = ready_q;
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem_q[rd_q];
    assign count     = cnt_q;

    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            wr_q    <= '0;
            rd_q    <= '0;
            cnt_q   <= '0;
            ready_q <= 1'b0;
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop || drop) begin
                rd_q <= rd_q + 1'b1;
            end
            cnt_q   <= cnt_d;
            // registered ready lags a cycle; push rechecks fullness live
            ready_q <= !hold && ((cnt_d != FULL) || overwrite);
        end
    end
endmodule

module afc_feature_config
    import afc_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        reset_n,
    input  wire logic        reg_start,
    input  wire logic [7:0]  reg_addr,
    input  wire logic        reg_rd,
    input  wire logic        reg_wr,
    input  wire logic [7:0]  reg_wdata,
    output logic [7:0]       reg_rdata,
    input  wire logic        bus_is_i2c,
    input  wire logic        i2c_select,
    input  wire logic        spi4_active,
    input  wire logic        res_ge14,
    input  wire logic        fifo_enable,
    input  wire logic        capture_stop_enable,
    input  wire logic        sniff_wake_event,
    input  wire logic        int_event,
    input  wire logic [2:0]  mode_select_field,
    input  wire logic [5:0]  thresh_count,
    input  wire logic        sample_valid,
    input  wire logic [47:0] sample_data,
    output logic             sample_ready,
    input  wire logic        spi_sclk_pin,
    input  wire logic        spi_csn_pin,
    output logic             serial_data_out_pin,
    output logic             serial_data_out_oe_n,
    input  wire logic        int_pin_in,
    output logic             interrupt_out_pin,
    output logic             interrupt_out_oe_n,
    output logic             ext_trigger
);
    logic [7:0]  feat_q;
    logic [7:0]  addr_q;
    logic [7:0]  wrap_end;
    logic        popped_q;
    logic        interrupt_pending_flag_q;
    logic        freeze_q;
    logic        clr;
    logic        rd_clear_ok;
    logic        pop;
    logic        f_valid;
    logic [47:0] head;
    logic [5:0]  f_count;
    logic [3:0]  flags;
    logic [15:0] z_out;
    logic [7:0]  rdata_d;
    logic [7:0]  rdata_q;
    logic [2:0]  sclk_s;
    logic [2:0]  csn_s;
    logic [2:0]  one_shot_trigger_mode_s;
    afc_tok_type tok_q;
    logic [3:0]  bits_q;
    logic [7:0]  shift_q;
    logic        sdo_oe_n_q;
    logic        int_oe_n_q;
    logic        pin_lo_q;
    logic        one_shot_trigger_mode_q;
    logic        one_shot_trigger_mode_edge;

    assign wrap_end = feat_q[AFC_BIT_WRAP] ? AFC_WRAP_LONG
                                           : AFC_WRAP_SHORT;
    // write of 0x09 always clears; a read clears only over I2C
    assign rd_clear_ok = bus_is_i2c
        && !(feat_q[AFC_BIT_WRCLR] && i2c_select);
    assign clr = (reg_wr && reg_addr == AFC_ADDR_STAT2)
        || (reg_rd && addr_q == AFC_ADDR_STAT2 && rd_clear_ok);
    assign pop = reg_rd && addr_q == AFC_ADDR_ZHI && f_valid
        && (feat_q[AFC_BIT_BURST] || !popped_q);
    assign flags = {interrupt_pending_flag_q, f_count >= thresh_count,
                    f_count == 6'(AFC_FIFO_DEPTH), !f_valid};

    afc_fifo #(.WIDTH(AFC_SAMPLE_W), .DEPTH(AFC_FIFO_DEPTH)) u_fifo (
        .clk       (mclk),
        .reset_n   (reset_n),
        .in_valid  (sample_valid),
        .in_data   (sample_data),
        .overwrite (feat_q[AFC_BIT_STREAM] && fifo_enable),
        .hold      (!fifo_enable || freeze_q),
        .out_ready (pop),
        .in_ready  (sample_ready),
        .out_valid (f_valid),
        .out_data  (head),
        .count     (f_count)
    );

    always_comb begin
        z_out = head[47:32];
        if (feat_q[AFC_BIT_FSTAT]) begin
            if (res_ge14) begin
                z_out = {head[47:36], flags};
            end else begin
                z_out = {flags, head[43:32]};
            end
        end
    end

    always_comb begin
        case (addr_q)
            8'h02:           rdata_d = head[7:0];
            8'h03:           rdata_d = head[15:8];
            8'h04:           rdata_d = head[23:16];
            8'h05:           rdata_d = head[31:24];
            AFC_ADDR_ZLO:    rdata_d = z_out[7:0];
            AFC_ADDR_ZHI:    rdata_d = z_out[15:8];
            AFC_ADDR_STAT1:  rdata_d = {4'h0, flags};
            AFC_ADDR_STAT2:  rdata_d = {7'h00, interrupt_pending_flag_q};
            AFC_ADDR_FEAT2:  rdata_d = feat_q;
            default:         rdata_d = 8'h00;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            feat_q <= AFC_FEAT2_RESET;
        end else if (reg_wr && reg_addr == AFC_ADDR_FEAT2) begin
            feat_q <= reg_wdata;
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            addr_q   <= AFC_ADDR_BASE;
            popped_q <= 1'b0;
            rdata_q  <= 8'h00;
        end else begin
            if (reg_start) begin
                addr_q   <= reg_addr;
                popped_q <= 1'b0;
            end else if (reg_rd) begin
                addr_q <= (addr_q == wrap_end) ? AFC_ADDR_BASE
                                               : addr_q + 8'h01;
                if (pop) begin
                    popped_q <= 1'b1;
                end
            end
            if (reg_rd) begin
                rdata_q <= rdata_d;
            end
        end
    end
    assign reg_rdata = rdata_q;

    // set wins over a clear in the same cycle
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            interrupt_pending_flag_q <= 1'b0;
            freeze_q   <= 1'b0;
        end else begin
            interrupt_pending_flag_q <= int_event || (interrupt_pending_flag_q && !clr);
            freeze_q   <= (capture_stop_enable && sniff_wake_event)
                          || (freeze_q && !clr);
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            sclk_s <= 3'b111;
            csn_s  <= 3'b111;
            one_shot_trigger_mode_s <= 3'b111;
        end else begin
            sclk_s <= {sclk_s[1:0], spi_sclk_pin};
            csn_s  <= {csn_s[1:0], spi_csn_pin};
            one_shot_trigger_mode_s <= {one_shot_trigger_mode_s[1:0], int_pin_in};
        end
    end

    // token only where the far end listens on a separate data line
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            tok_q      <= AFC_TOK_IDLE;
            bits_q     <= 4'h0;
            shift_q    <= 8'h00;
            sdo_oe_n_q <= 1'b1;
        end else if (csn_s[1]) begin
            tok_q      <= AFC_TOK_IDLE;
            sdo_oe_n_q <= 1'b1;
        end else begin
            case (tok_q)
                AFC_TOK_IDLE: begin
                    if (csn_s[2] && feat_q[AFC_BIT_SPISTAT]
                        && spi4_active) begin
                        tok_q      <= AFC_TOK_SHIFT;
                        bits_q     <= AFC_TOKEN_BITS;
                        shift_q    <= {flags, 4'h0};
                        sdo_oe_n_q <= 1'b0;
                    end else if (csn_s[2]) begin
                        tok_q <= AFC_TOK_DONE;
                    end
                end
                AFC_TOK_SHIFT: begin
                    if (sclk_s[2] && !sclk_s[1]) begin
                        shift_q <= {shift_q[6:0], 1'b0};
                        bits_q  <= bits_q - 4'h1;
                        if (bits_q == 4'h1) begin
                            tok_q      <= AFC_TOK_DONE;
                            sdo_oe_n_q <= 1'b1;
                        end
                    end
                end
                AFC_TOK_DONE: tok_q <= AFC_TOK_DONE;
                default:      tok_q <= AFC_TOK_IDLE;
            endcase
        end
    end
    assign serial_data_out_pin  = shift_q[7];
    assign serial_data_out_oe_n = sdo_oe_n_q;

    assign one_shot_trigger_mode_edge = feat_q[AFC_BIT_POL] ? (one_shot_trigger_mode_s[1] && !one_shot_trigger_mode_s[2])
                                           : (!one_shot_trigger_mode_s[1] && one_shot_trigger_mode_s[2]);

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            one_shot_trigger_mode_q     <= 1'b0;
            int_oe_n_q <= 1'b1;
            pin_lo_q   <= 1'b0;
        end else begin
            one_shot_trigger_mode_q <= feat_q[AFC_BIT_EXTEN] && one_shot_trigger_mode_edge
                      && mode_select_field == AFC_MODE_ONE_SHOT;
            // open drain: released as an input while trigger mode is on
            int_oe_n_q <= feat_q[AFC_BIT_EXTEN] || !interrupt_pending_flag_q;
            pin_lo_q   <= 1'b0;
        end
    end
    assign ext_trigger        = one_shot_trigger_mode_q;
    assign interrupt_out_oe_n = int_oe_n_q;
    assign interrupt_out_pin  = pin_lo_q;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    sequence s_csn_fall;
        csn_s[2] && !csn_s[1] && tok_q == AFC_TOK_IDLE;
    endsequence
    sequence s_token_on;
        feat_q[AFC_BIT_SPISTAT] && spi4_active;
    endsequence

    a_wrap_short: assert property (reg_rd && !reg_start
        && !feat_q[AFC_BIT_WRAP] && addr_q == 8'h07 |=> addr_q == 8'h02)
        else $error("short wrap did not return to 0x02");
    a_wrap_long: assert property (reg_rd && !reg_start
        && feat_q[AFC_BIT_WRAP] && addr_q == 8'h07
        ##1 reg_rd && !reg_start ##1 reg_rd && !reg_start
        |=> addr_q == 8'h02)
        else $error("long wrap did not pass 0x09");
    a_long_pop: assert property (reg_rd && addr_q == 8'h07
        && feat_q[AFC_BIT_BURST] && f_valid && !sample_valid
        |=> f_count == $past(f_count) - 6'h01)
        else $error("long burst did not advance sample");
    a_short_once: assert property (pop && !feat_q[AFC_BIT_BURST]
        ##1 !reg_start [*1] |-> !pop)
        else $error("short burst popped twice");
    a_read_clear: assert property (reg_rd && addr_q == 8'h09
        && bus_is_i2c && !(feat_q[AFC_BIT_WRCLR] && i2c_select)
        && !int_event |=> !interrupt_pending_flag_q)
        else $error("read of 0x09 did not clear");
    a_read_keep: assert property (reg_rd && addr_q == 8'h09
        && interrupt_pending_flag_q && !(reg_wr && reg_addr == 8'h09)
        && (!bus_is_i2c || (feat_q[AFC_BIT_WRCLR] && i2c_select))
        |=> interrupt_pending_flag_q)
        else $error("interrupt lost on read");
    a_write_clear: assert property (reg_wr && reg_addr == 8'h09
        && !int_event |=> !interrupt_pending_flag_q)
        else $error("write of 0x09 did not clear");
    a_z_plain: assert property (reg_rd && addr_q == 8'h07
        && !feat_q[AFC_BIT_FSTAT] |=> reg_rdata == $past(head[47:40]))
        else $error("Z altered with token off");
    a_z_token: assert property (reg_rd && addr_q == 8'h07
        && feat_q[AFC_BIT_FSTAT] && !res_ge14
        |=> reg_rdata[7:4] == $past(flags))
        else $error("Z token missing");
    a_full_refuse: assert property (f_count == 6'd32
        && !feat_q[AFC_BIT_STREAM] && !pop |=> f_count == 6'd32
        && $stable(head))
        else $error("full FIFO accepted sample");
    a_one_shot_trigger_mode_edge: assert property (feat_q[AFC_BIT_EXTEN]
        && mode_select_field == 3'b111 && !feat_q[AFC_BIT_POL]
        && $fell(one_shot_trigger_mode_s[1]) |=> ext_trigger)
        else $error("falling trigger missed");
    a_pin_input: assert property (feat_q[AFC_BIT_EXTEN]
        ##1 feat_q[AFC_BIT_EXTEN] |-> interrupt_out_oe_n)
        else $error("trigger pin driven");
    a_token_first: assert property (s_csn_fall ##0 s_token_on
        ##1 !csn_s[1] |-> !serial_data_out_oe_n)
        else $error("status token not driven");
endmodule

// ===== afc_host_model.sv
`timescale 1ns/1ps
module afc_host_model (
    output logic      sclk,
    output logic      csn,
    output logic      one_shot_trigger_mode_pin,
    input  wire logic sdo
);
    // link clock stands still between frames, idle high
    initial begin
        sclk = 1'b1;
        csn = 1'b1;
        one_shot_trigger_mode_pin = 1'b1;
    end
    // 80 ns link period; each bit is taken before the falling edge
    // that shifts the next one out
    task automatic frame(output logic [7:0] b);
        csn = 1'b0;
        #80;
        for (int i = 7; i >= 0; i--) begin
            b[i] = sdo;
            sclk = 1'b0;
            #40;
            sclk = 1'b1;
            #40;
        end
        csn = 1'b1;
        // a back-to-back frame must still show a deselect gap
        #80;
    endtask
    task automatic pin(input logic v);
        one_shot_trigger_mode_pin = v;
    endtask
endmodule

// ===== tb.sv
`timescale 1ns/1ps
module tb;
    import afc_pkg::*;
    logic        mclk, reset_n, reg_start, reg_rd, reg_wr, bus_is_i2c;
    logic        i2c_select, spi4_active, res_ge14, fifo_enable, rd_seen;
    logic        int_event, sample_valid, sample_ready, sclk, csn, tpin;
    logic        sdo, sdo_oe_n, int_oe_n, ext_trigger, int_out;
    logic        cap_stop, sniff_wake;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, tok;
    logic [2:0]  mode_select_field;
    logic [5:0]  thresh_count;
    logic [47:0] sample_data;
    logic [47:0] s[34];
    logic [15:0] q[$];
    logic [15:0] nt;
    int          n_mismatch, comparisons, n_one_shot_trigger_mode, one_shot_trigger_mode_base;
    // {i2c, write-clear, i2c select, clear by write, still pending}
    logic [4:0]  ic[6] = '{5'h10, 5'h1D, 5'h1E, 5'h18, 5'h09, 5'h02};

    always #5 mclk = ~mclk;

    afc_feature_config u_afc_feature_config (
        .mclk(mclk), .reset_n(reset_n), .reg_start(reg_start),
        .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .bus_is_i2c(bus_is_i2c), .i2c_select(i2c_select),
        .spi4_active(spi4_active), .res_ge14(res_ge14),
        .fifo_enable(fifo_enable), .capture_stop_enable(cap_stop),
        .sniff_wake_event(sniff_wake), .int_event(int_event),
        .mode_select_field(mode_select_field),
        .thresh_count(thresh_count), .sample_valid(sample_valid),
        .sample_data(sample_data), .sample_ready(sample_ready),
        .spi_sclk_pin(sclk), .spi_csn_pin(csn),
        .serial_data_out_pin(sdo), .serial_data_out_oe_n(sdo_oe_n),
        .int_pin_in(tpin), .interrupt_out_pin(int_out),
        .interrupt_out_oe_n(int_oe_n), .ext_trigger(ext_trigger)
    );
    afc_host_model u_afc_host_model (
        .sclk(sclk), .csn(csn), .one_shot_trigger_mode_pin(tpin), .sdo(sdo)
    );

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_of_test;
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // one strobe per cycle; a read notes {mask, expected} in the queue
    task automatic bus(input logic [2:0] k, input logic [7:0] a,
                       input logic [7:0] d, input logic [7:0] m);
        @(negedge mclk);
        {reg_start, reg_rd, reg_wr} = k;
        reg_addr = a;
        reg_wdata = d;
        if (k[1]) q.push_back({m, d});
    endtask
    task automatic rd(input logic [7:0] e, input logic [7:0] m = 8'hFF);
        bus(3'b010, 8'h00, e, m);
    endtask
    task automatic rstart(input logic [7:0] a);
        bus(3'b100, a, 8'h00, 8'h00);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(3'b001, a, d, 8'h00);
        bus(3'b000, a, d, 8'h00);
    endtask
    task automatic pulse;
        @(negedge mclk);
        {reg_start, reg_rd, reg_wr} = 3'b000;
        int_event = 1'b1;
        @(negedge mclk);
        int_event = 1'b0;
    endtask
    task automatic push(input logic [47:0] d);
        int n;
        n = 0;
        @(negedge mclk);
        {reg_start, reg_rd, reg_wr} = 3'b000;
        sample_valid = 1'b1;
        sample_data = d;
        while (sample_ready !== 1'b1 && n < 20) begin
            @(negedge mclk);
            n++;
        end
        @(negedge mclk);
        sample_valid = 1'b0;
    endtask
    task automatic edges(input int n);
        repeat (n) begin
            @(negedge mclk);
            {reg_start, reg_rd, reg_wr} = 3'b000;
        end
    endtask

    // read data lands on the same edge that takes the strobe; checked half a cycle later
    always @(posedge mclk) rd_seen <= reg_rd;
    always @(negedge mclk) begin
        if (rd_seen === 1'b1 && q.size() > 0) begin
            nt = q.pop_front();
            check(reg_rdata & nt[15:8], nt[7:0]);
        end
    end
    always @(posedge mclk) if (ext_trigger === 1'b1) n_one_shot_trigger_mode++;

    initial begin
        #500us;
        n_mismatch++;
        end_of_test;
    end

    initial begin
        {mclk, reset_n, reg_start, reg_rd, reg_wr} = '0;
        {int_event, sample_valid, i2c_select, spi4_active} = '0;
        {cap_stop, sniff_wake} = 2'b00;
        {bus_is_i2c, fifo_enable, res_ge14} = 3'b110;
        {reg_addr, reg_wdata, sample_data} = '0;
        mode_select_field = 3'b000;
        thresh_count = 6'h01;
        void'($urandom(45876));
        foreach (s[i]) s[i] = {$urandom, $urandom};
        edges(2);
        reset_n = 1'b1;
        rstart(AFC_ADDR_FEAT2);
        rd(AFC_FEAT2_RESET);
        wr(AFC_ADDR_FEAT2, 8'h5A);
        rstart(AFC_ADDR_FEAT2);
        rd(8'h5A);
        // short burst, both wrap points; status token off
        for (int i = 0; i < 3; i++) push(s[i]);
        wr(AFC_ADDR_FEAT2, 8'h00);
        rstart(AFC_ADDR_BASE);
        for (int j = 0; j < 6; j++) rd(s[0][8*j+:8]);
        rd(s[1][7:0]);
        wr(AFC_ADDR_FEAT2, 8'h01);
        rstart(AFC_ADDR_BASE);
        for (int j = 0; j < 6; j++) rd(s[1][8*j+:8]);
        rd(8'h00, 8'h03);
        rd(8'h00, 8'h00);
        rd(s[2][7:0]);
        // flags come from the state at read time
        pulse;
        wr(AFC_ADDR_FEAT2, 8'h08);
        rstart(AFC_ADDR_BASE);
        for (int j = 0; j < 5; j++) rd(s[2][8*j+:8]);
        rd({4'hC, s[2][43:40]});
        push(s[3]);
        res_ge14 = 1'b1;
        rstart(AFC_ADDR_BASE);
        for (int j = 0; j < 4; j++) rd(s[3][8*j+:8]);
        rd({s[3][39:36], 4'hC});
        rd(s[3][47:40]);
        wr(AFC_ADDR_STAT2, 8'h00);
        // each way of clearing pending interrupts
        foreach (ic[i]) begin
            bus_is_i2c = ic[i][4];
            i2c_select = ic[i][2];
            wr(AFC_ADDR_FEAT2, {3'b000, ic[i][3], 4'h0});
            pulse;
            if (ic[i][1]) wr(AFC_ADDR_STAT2, 8'($urandom));
            else begin
                rstart(AFC_ADDR_STAT2);
                rd(8'h00, 8'h00);
            end
            rstart(AFC_ADDR_STAT2);
            rd({7'h00, ic[i][0]}, 8'h01);
            wr(AFC_ADDR_STAT2, 8'h00);
        end
        {bus_is_i2c, i2c_select} = 2'b10;
        // fill, refuse, then stream one more and drain in one burst
        wr(AFC_ADDR_FEAT2, 8'h02);
        for (int i = 0; i < 32; i++) push(s[i]);
        edges(4);
        check({7'h00, sample_ready}, 8'h00);
        sample_valid = 1'b0;
        rstart(AFC_ADDR_STAT1);
        rd(8'h02, 8'h03);
        wr(AFC_ADDR_FEAT2, 8'h22);
        push(s[32]);
        rstart(AFC_ADDR_BASE);
        for (int i = 1; i < 33; i++)
            for (int j = 0; j < 6; j++)
                rd(s[i][8*j+:8]);
        rstart(AFC_ADDR_STAT1);
        rd(8'h01, 8'h03);
        // status byte leads 4-wire frames only
        pulse;
        wr(AFC_ADDR_FEAT2, 8'h04);
        check({6'h00, int_out, int_oe_n}, 8'h00);
        bus_is_i2c = 1'b0;
        for (int k = 0; k < 2; k++) begin
            spi4_active = k[0];
            fork
                u_afc_host_model.frame(tok);
                begin
                    #300;
                    check({7'h00, sdo_oe_n}, {7'h00, !k[0]});
                end
            join
            if (k == 1) check(tok, 8'h90);
        end
        wr(AFC_ADDR_STAT2, 8'h00);
        // external trigger, both polarities, then outside one-shot
        mode_select_field = AFC_MODE_ONE_SHOT;
        for (int p = 0; p < 3; p++) begin
            if (p == 2) mode_select_field = 3'b101;
            wr(AFC_ADDR_FEAT2, {1'b1, p[0], 6'h00});
            u_afc_host_model.pin(!p[0]);
            edges(10);
            check({6'h00, int_out, int_oe_n}, 8'h01);
            one_shot_trigger_mode_base = n_one_shot_trigger_mode;
            u_afc_host_model.pin(p[0]);
            edges(10);
            check(8'(n_one_shot_trigger_mode - one_shot_trigger_mode_base), {7'h00, p < 2});
            u_afc_host_model.pin(!p[0]);
            edges(10);
            check(8'(n_one_shot_trigger_mode - one_shot_trigger_mode_base), {7'h00, p < 2});
        end
        // capture stop holds the buffer shut until interrupts clear
        @(negedge mclk);
        {cap_stop, sniff_wake} = 2'b11;
        @(negedge mclk);
        sniff_wake = 1'b0;
        edges(3);
        check({7'h00, sample_ready}, 8'h00);
        wr(AFC_ADDR_STAT2, 8'h00);
        edges(2);
        check({7'h00, sample_ready}, 8'h01);
        bus(3'b000, 8'h00, 8'h00, 8'h00);
        edges(3);
        check(8'(q.size()), 8'h00);
        end_of_test;
    end
endmodule
